// File: logic/clrf_framer.sv
// Cross-lane tag record framer: record to byte stream, binary or text
`default_nettype none
`timescale 1ns/1ps
module clrf_framer (
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              rst,
	// Record from the reader logic
	input  wire logic              rec_valid,
	input  wire clrf_pkg::clrf_rec_t rec,
	input  wire logic              text_mode,
	output var  logic              rec_ready,
	// Byte stream to the host link
	output var  clrf_pkg::clrf_byte_t out,
	input  wire logic              out_ready
);
	clrf_pkg::clrf_state_t q;
	clrf_pkg::clrf_state_t d;
	logic                  fin;

	function automatic logic [255:0] pack_image(
		input clrf_pkg::clrf_image_t im);
		pack_image = {
			im.ro.header, im.ro.tag_type,
			im.ro.application_identifier,
			im.ro.group_id,
			im.ro.issuing_agency_id, im.ro.serial_number,
			im.ro.vehicle_class, im.ro.revenue_type,
			im.ro.commission_status,
			im.ro.mounting_location,
			im.ro.agency_data_1, im.ro.regional_class,
			im.ro.agency_data_2,
			im.rw.reader_id, im.rw.prior_read_date,
			im.rw.prior_read_time,
			im.rw.agency_id, im.rw.plaza_id, im.rw.lane_id,
			im.rw.txn_date, im.rw.txn_time,
			im.rw.txn_vehicle_class, im.rw.future,
			im.rw.agency_data,
			im.rw.txn_number,
			im.spare};
	endfunction

	function automatic logic [7:0] hexc(input logic [3:0] n);
		if (n < clrf_pkg::NIB_TEN) begin
			hexc = clrf_pkg::DIGIT_BASE + {4'h0, n};
		end else begin
			hexc = clrf_pkg::ALPHA_BASE + {4'h0, n};
		end
	endfunction

	always_comb begin
		d = q;
		fin = 1'b0;
		// Output slot frees on handshake so bytes can flow back to back
		if (q.out.valid && out_ready) begin
			d.out.valid = 1'b0;
			d.out.last = 1'b0;
		end
		case (q.phase)
			clrf_pkg::PH_IDLE: begin
				if (rec_valid && q.rdy) begin
					d.frame = {clrf_pkg::REC_TYPE,
						pack_image(rec.image),
						rec.check, rec.antenna};
					d.text = text_mode;
					d.idx = '0;
					d.nib = 1'b0;
					d.rdy = 1'b0;
					d.phase = text_mode ? clrf_pkg::PH_PREFIX
						: clrf_pkg::PH_BODY;
				end
			end
			clrf_pkg::PH_PREFIX: begin
				if (!d.out.valid) begin
					d.out.valid = 1'b1;
					d.out.data = clrf_pkg::HASH_CHAR;
					d.out.last = 1'b0;
					d.phase = clrf_pkg::PH_BODY;
				end
			end
			clrf_pkg::PH_BODY: begin
				if (!d.out.valid) begin
					fin = (q.idx == clrf_pkg::LAST_BYTE) && (!q.text || q.nib);
					d.out.valid = 1'b1;
					d.out.last = fin;
					if (q.text) begin
						// High nibble first keeps the bit order MSB first
						d.out.data = hexc(q.nib
							? q.frame[clrf_pkg::FRAME_W-5 -: 4]
							: q.frame[clrf_pkg::FRAME_W-1 -: 4]);
						d.nib = !q.nib;
					end else begin
						d.out.data = q.frame[clrf_pkg::FRAME_W-1 -: 8];
					end
					if (!q.text || q.nib) begin
						d.frame = {q.frame[clrf_pkg::FRAME_W-9:0], 8'h00};
						d.idx = q.idx + 6'h01;
					end
					if (fin) begin
						d.phase = clrf_pkg::PH_IDLE;
						d.rdy = 1'b1;
					end
				end
			end
			default: begin
				d = clrf_pkg::ST_RST;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			q <= clrf_pkg::ST_RST;
		end else begin
			q <= d;
		end
	end

	assign rec_ready = q.rdy;
	assign out = q.out;

	// Checking helpers: handshake count and a copy of the loaded frame
	logic [6:0]                  hc_q;
	logic [clrf_pkg::FRAME_W-1:0] fr_h;
	logic                        txt_h;
	logic                        hs;
	logic                        acc;
	logic [8:0]                  bpos;
	logic [7:0]                  exp_b;
	logic [3:0]                  exp_n;

	assign hs = q.out.valid && out_ready;
	assign acc = rec_valid && q.rdy;
	assign bpos = txt_h ? (9'((hc_q - 7'h01) >> 1) * 9'h008)
		: (9'(hc_q) * 9'h008);
	assign exp_b = fr_h[9'(clrf_pkg::FRAME_W-1) - bpos -: 8];
	assign exp_n = hc_q[0] ? exp_b[7:4] : exp_b[3:0];

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			hc_q <= 7'h00;
			fr_h <= '0;
			txt_h <= 1'b0;
		end else begin
			if (hs) begin
				hc_q <= q.out.last ? 7'h00 : hc_q + 7'h01;
			end
			if (acc) begin
				fr_h <= {clrf_pkg::REC_TYPE, 256'(rec.image),
					rec.check, rec.antenna};
				txt_h <= text_mode;
			end
		end
	end

	sequence s_accept;
		q.phase == clrf_pkg::PH_IDLE && acc;
	endsequence

	sequence s_load;
		s_accept ##1 q.phase != clrf_pkg::PH_IDLE;
	endsequence

	a_type_bytes: assert property (@(posedge mclk) disable iff (rst)
		hs && !txt_h && hc_q < 7'h02 |-> q.out.data == (hc_q == 7'h00
			? clrf_pkg::REC_TYPE[15:8] : clrf_pkg::REC_TYPE[7:0]))
		else $error("record type byte wrong");
	a_bin_order: assert property (@(posedge mclk) disable iff (rst)
		hs && !txt_h |-> q.out.data == exp_b)
		else $error("binary byte out of order");
	a_text_hex: assert property (@(posedge mclk) disable iff (rst)
		hs && txt_h && hc_q != 7'h00 |-> q.out.data == hexc(exp_n))
		else $error("text character wrong");
	a_text_hash: assert property (@(posedge mclk) disable iff (rst)
		hs && txt_h && hc_q == 7'h00 |-> q.out.data == clrf_pkg::HASH_CHAR)
		else $error("text record lacks hash");
	a_last_pos: assert property (@(posedge mclk) disable iff (rst)
		hs |-> q.out.last == (hc_q == (txt_h ? clrf_pkg::LAST_CHAR[6:0]
			: {1'b0, clrf_pkg::LAST_BYTE})))
		else $error("last flag misplaced");
	a_app_straddle: assert property (@(posedge mclk) disable iff (rst)
		s_accept |=> q.frame[273:271]
			== $past(rec.image.ro.application_identifier))
		else $error("application id misplaced");
	a_group_pos: assert property (@(posedge mclk) disable iff (rst)
		s_load |-> q.frame[270:264] == $past(rec.image.ro.group_id))
		else $error("group id misplaced");
	a_txn_check: assert property (@(posedge mclk) disable iff (rst)
		s_load |-> q.frame[55:40] == $past(rec.image.rw.txn_number)
			&& q.frame[23:8] == $past(rec.check))
		else $error("transaction number or check misplaced");
	a_stall_hold: assert property (@(posedge mclk) disable iff (rst)
		q.out.valid && !out_ready |=> q.out.valid && $stable(q.out.data))
		else $error("byte dropped under stall");
	a_busy_block: assert property (@(posedge mclk) disable iff (rst)
		q.phase != clrf_pkg::PH_IDLE |-> !q.rdy)
		else $error("new record taken mid-frame");
endmodule
`default_nettype wire

// File: logic/clrf_pkg.sv
// Shared constants and types for the cross-lane tag record framer
`default_nettype none
package clrf_pkg;
	localparam logic [15:0] REC_TYPE   = 16'h5027;
	localparam int          FRAME_W    = 296;
	localparam logic [5:0]  LAST_BYTE  = 6'h24;
	localparam logic [7:0]  LAST_CHAR  = 8'h4A;
	localparam logic [7:0]  HASH_CHAR  = 8'h23;
	localparam logic [7:0]  DIGIT_BASE = 8'h30;
	localparam logic [7:0]  ALPHA_BASE = 8'h37;
	localparam logic [3:0]  NIB_TEN    = 4'hA;

	typedef struct packed {
		logic [2:0]  header;
		logic [2:0]  tag_type;
		logic [2:0]  application_identifier;
		logic [6:0]  group_id;
		logic [6:0]  issuing_agency_id;
		logic [23:0] serial_number;
		logic [10:0] vehicle_class;
		logic [3:0]  revenue_type;
		logic        commission_status;
		logic [1:0]  mounting_location;
		logic [2:0]  agency_data_1;
		logic [3:0]  regional_class;
		logic [23:0] agency_data_2;
	} clrf_ro_t;

	typedef struct packed {
		logic [11:0] reader_id;
		logic [8:0]  prior_read_date;
		logic [16:0] prior_read_time;
		logic [6:0]  agency_id;
		logic [6:0]  plaza_id;
		logic [4:0]  lane_id;
		logic [8:0]  txn_date;
		logic [16:0] txn_time;
		logic [10:0] txn_vehicle_class;
		logic [3:0]  future;
		logic [29:0] agency_data;
		logic [15:0] txn_number;
	} clrf_rw_t;

	// Named fields fill 240 bits; spare tail pads the image to 256
	typedef struct packed {
		clrf_ro_t    ro;
		clrf_rw_t    rw;
		logic [15:0] spare;
	} clrf_image_t;

	typedef struct packed {
		clrf_image_t image;
		logic [15:0] check;
		logic [7:0]  antenna;
	} clrf_rec_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       last;
	} clrf_byte_t;

	typedef enum logic [1:0] {
		PH_IDLE   = 2'b00,
		PH_PREFIX = 2'b01,
		PH_BODY   = 2'b11
	} clrf_phase_t;

	typedef struct packed {
		clrf_phase_t        phase;
		logic               rdy;
		logic               text;
		logic               nib;
		logic [5:0]         idx;
		logic [FRAME_W-1:0] frame;
		clrf_byte_t         out;
	} clrf_state_t;

	localparam clrf_state_t ST_RST = '{
		phase: PH_IDLE, rdy: 1'b1, text: 1'b0, nib: 1'b0,
		idx: 6'h00, frame: '0, out: '0};
endpackage
`default_nettype wire

// File: tb/clrf_host_model.sv
// Host link model: takes framed bytes, can stall every other cycle
`default_nettype none
`timescale 1ns/1ps
module clrf_host_model (
	// Clock and reset
	input  wire logic                 mclk,
	input  wire logic                 rst,
	// Byte stream from the framer
	input  wire clrf_pkg::clrf_byte_t out,
	output var  logic                 out_ready,
	// Test control
	input  wire logic                 stall
);
	logic                 tick_q = 1'b0;
	logic                 wait_q = 1'b0;
	clrf_pkg::clrf_byte_t last_q;
	logic [8:0]           got[$];
	int                   hold_err = 0;
	// Alternate refusals so every byte after the first of a frame also sits through a held cycle
	always @(posedge mclk or posedge rst) begin
		if (rst)
			tick_q <= 1'b0;
		else
			tick_q <= ~tick_q;
	end
	assign out_ready = ~stall | tick_q;
	always @(posedge mclk) begin
		if (wait_q && out !== last_q)
			hold_err++;
		wait_q <= !rst && out.valid && !out_ready;
		last_q <= out;
		if (!rst && out.valid && out_ready)
			got.push_back({out.last, out.data});
	end
endmodule
`default_nettype wire

// File: tb/tb_clrf_framer.sv
// Self-checking bench for the cross-lane tag record framer
`default_nettype none
`timescale 1ns/1ps
module tb_clrf_framer;
	logic                 mclk = 1'b0;
	logic                 rst = 1'b1;
	logic                 rec_valid = 1'b0;
	logic                 text_mode = 1'b0;
	logic                 stall = 1'b0;
	clrf_pkg::clrf_rec_t  rec = '0;
	logic                 rec_ready;
	logic                 out_ready;
	clrf_pkg::clrf_byte_t out;
	clrf_pkg::clrf_image_t ex;
	int                   err_count = 0;
	int                   checked = 0;
	always #50 mclk = ~mclk;
	clrf_framer u_dut (.mclk(mclk), .rst(rst), .rec_valid(rec_valid),
		.rec(rec), .text_mode(text_mode), .rec_ready(rec_ready),
		.out(out), .out_ready(out_ready));
	clrf_host_model u_host (.mclk(mclk), .rst(rst), .out(out),
		.out_ready(out_ready), .stall(stall));
	task automatic cmp(input string nm, input logic [8:0] e, s);
		checked++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	function automatic logic [7:0] hx(input logic [3:0] v);
		return (v < 4'hA) ? 8'h30 + v : 8'h37 + v;
	endfunction
	task automatic run(input logic txt, stl, input logic [255:0] im,
		input logic [7:0] ant);
		logic [295:0] f;
		logic [8:0]   e[$];
		int           n;
		f = {16'h5027, im, {ant, ~ant}, ant};
		if (txt)
			e.push_back(9'h023);
		for (int j = 0; j < 74; j++) begin
			if (txt)
				e.push_back({1'b0, hx(f[295-4*j -: 4])});
			else if (j < 37)
				e.push_back({1'b0, f[295-8*j -: 8]});
		end
		e[e.size()-1][8] = 1'b1;
		@(posedge mclk);
		rec <= '{ex, {ant, ~ant}, ant};
		if (im != ex)
			rec.image <= im;
		text_mode <= txt;
		stall <= stl;
		rec_valid <= 1'b1;
		do @(posedge mclk); while (rec_ready !== 1'b1);
		rec_valid <= 1'b0;
		n = 0;
		while (u_host.got.size() < e.size() && n < 400) begin
			@(posedge mclk);
			n++;
		end
		repeat (2) @(posedge mclk);
		cmp("count", e.size(), u_host.got.size());
		for (int i = 0; i < e.size(); i++)
			cmp("byte", e[i], u_host.got[i]);
		cmp("ready", 9'h001, rec_ready);
		cmp("hold", 9'h000, u_host.hold_err);
		u_host.got.delete();
	endtask
	task automatic end_of_test();
		if (err_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		ex = '{ro: '{7, 3, 1, 65, 15, 65113, 72, 0, 0, 0, 0, 1, 362245},
			rw: '{731, 341, 46168, 15, 5, 5, 354, 46142, 1363, 8,
			50724865, 43771}, spare: 16'h5983};
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		#1;
		cmp("rst_ready", 9'h001, rec_ready);
		cmp("rst_valid", 9'h000, out.valid);
		// Image must equal the documented example, field by field
		run(1'b0, 1'b0, 256'hECC11E01FCB21200010587052DBAAAD1607852D89687D54E03060001AAFB5983, 8'h01);
		run(1'b1, 1'b1, ex, 8'h3C);
		run(1'b0, 1'b1, ~ex, 8'hC5);
		end_of_test();
	end
	initial begin
		#2000000;
		err_count++;
		end_of_test();
	end
endmodule
`default_nettype wire
